// file: rle_return_link_encoder.sv
// return link encoder: default read sequencing and line coding
// Overview of operation
// - every memory bit, default read or read-word answer, passes through the line coder.
// - a high coder output turns the load modulator on, low turns it off.
// - a manchester zero is low in the first half and high in the second.
// - a manchester one is high in the first half and low in the second.
// - bi-phase inverts the output at the start of every bit.
// - a bi-phase zero inverts again at mid-period.
// - a bi-phase one keeps its level through mid-period.
// - pigeon default read uses manchester at 64 field periods per bit.
// - pigeon default read sends word 5 whole, then low 16 bits of words 6 and 7.
// - fdx-b default read sends words 5 to 8 as a 128-bit frame.
// - fdx-b uses bi-phase at 32 field periods per bit.
`timescale 1ns/100ps
`include "rle_map.svh"
module rle_return_link_encoder
    import rle_pkg::*;
#(
    parameter int RW = 7
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic RF_TICK,
    input wire logic DEFAULT_READ_EN,
    input wire logic PIGEON_MODE_BIT,
    input wire logic ANSWER_CODE_BIPHASE,
    input wire logic [RW-1:0] ANSWER_RATE,
    input wire logic ANSWER_BIT_VALID,
    input wire logic ANSWER_BIT,
    output logic ANSWER_BIT_READY,
    output rle_mem_req_t MEM_REQ,
    input wire rle_mem_rsp_t MEM_RSP,
    output logic MOD_ON
);
    // sequencer state
    rle_src_t src_ff, nxt_src;
    logic [3:0] word_ff, nxt_word;
    logic [31:0] shf_ff, nxt_shf;
    logic [5:0] left_ff, nxt_left;
    logic busy_ff, nxt_busy;
    logic wait_ff, nxt_wait;
    logic req_ff, nxt_req;
    // coder hookup: load strobe, bit value and end of bit
    logic bit_load, bit_val, bit_done;
    logic free;
    // coding and rate handed to the coder
    rle_code_t code;
    logic [RW-1:0] rate;
    logic [3:0] last_word;
    logic [5:0] word_bits;

    // ====================================================================
    // mode selection
    // ====================================================================
    // pigeon mode bit picks the pigeon layout
    // pigeon is manchester at 64 periods
    // fdx-b is bi-phase at 32 periods
    always_comb begin
        // an answer bit taken straight from idle already needs the answer coding
        if (src_ff == RLE_SRC_ANSWER || (src_ff == RLE_SRC_IDLE && ANSWER_BIT_VALID)) begin
            code = ANSWER_CODE_BIPHASE ? RLE_CODE_BIPHASE : RLE_CODE_MANCHESTER;
            rate = ANSWER_RATE;
        end else if (PIGEON_MODE_BIT) begin
            code = RLE_CODE_MANCHESTER;
            rate = RW'(`RLE_RATE_PIGEON);
        end else begin
            code = RLE_CODE_BIPHASE;
            rate = RW'(`RLE_RATE_FDXB);
        end
    end

    // the mode bit must hold still during a frame: both values below follow it
    // live, so a change in mid-frame would alter the later word lengths and the wrap point
    // word 5 whole, words 6 and 7 low half
    // fdx-b runs up to word 8
    assign last_word = PIGEON_MODE_BIT ? `RLE_PIGEON_LAST_WORD : `RLE_FDXB_LAST_WORD;
    assign word_bits = (PIGEON_MODE_BIT && word_ff != `RLE_PIGEON_FIRST_WORD) ?
                       `RLE_HALF_WORD_BITS : `RLE_FULL_WORD_BITS;

    // ====================================================================
    // answer stream handshake
    // ====================================================================
    // coder is free when idle or finishing the current bit
    // a new bit loads on the edge that ends the old one, so bits abut
    assign free = !busy_ff || bit_done;
    assign ANSWER_BIT_READY = free && !wait_ff && (src_ff != RLE_SRC_DEFAULT);

    // ====================================================================
    // bit sequencer
    // ====================================================================
    // hold everything by default; the fetch request is a one-cycle pulse
    always_comb begin
        nxt_src = src_ff;
        nxt_word = word_ff;
        nxt_shf = shf_ff;
        nxt_left = left_ff;
        nxt_busy = busy_ff;
        nxt_wait = wait_ff;
        nxt_req = 1'b0;
        bit_load = 1'b0;
        bit_val = 1'b0;
        // the running bit ends here unless a new one loads below
        if (bit_done) begin
            nxt_busy = 1'b0;
        end
        case (src_ff)
            // idle: an answer bit wins over starting a default frame
            RLE_SRC_IDLE: begin
                if (ANSWER_BIT_VALID && free) begin
                    // ready stays high in idle, so the bit must be taken on this edge
                    // first answer bit goes straight into the coder
                    nxt_src = RLE_SRC_ANSWER;
                    bit_load = 1'b1;
                    bit_val = ANSWER_BIT;
                    nxt_busy = 1'b1;
                end else if (DEFAULT_READ_EN && free) begin
                    nxt_src = RLE_SRC_DEFAULT;
                    nxt_word = PIGEON_MODE_BIT ? `RLE_PIGEON_FIRST_WORD : `RLE_FDXB_FIRST_WORD;
                    nxt_wait = 1'b1;
                    nxt_req = 1'b1;
                end
            end
            // default: fetch a word, then shift it out lsb first
            RLE_SRC_DEFAULT: begin
                // a response that comes while not waiting is ignored
                if (wait_ff) begin
                    if (MEM_RSP.valid) begin
                        nxt_wait = 1'b0;
                        nxt_shf = MEM_RSP.data;
                        nxt_left = word_bits;
                    end
                end else if (free) begin
                    if (left_ff != 6'h00) begin
                        // memory bit, lsb first, into the coder
                        bit_load = 1'b1;
                        bit_val = shf_ff[0];
                        nxt_busy = 1'b1;
                        nxt_shf = shf_ff >> 1;
                        nxt_left = left_ff - 6'h01;
                    // word boundary: yield to an answer or fetch the next word; the
                    // fetch holds the last level of a word for the memory latency
                    end else if (!DEFAULT_READ_EN || ANSWER_BIT_VALID) begin
                        nxt_src = RLE_SRC_IDLE; // leave at a word boundary
                    end else begin
                        // the frame wraps to its first word, so default read repeats
                        nxt_word = (word_ff == last_word) ?
                            (PIGEON_MODE_BIT ? `RLE_PIGEON_FIRST_WORD : `RLE_FDXB_FIRST_WORD) :
                            word_ff + 4'h1;
                        nxt_wait = 1'b1;
                        nxt_req = 1'b1;
                    end
                end
            end
            // answer: keep taking bits while the stream stays valid
            RLE_SRC_ANSWER: begin
                if (free) begin
                    if (ANSWER_BIT_VALID) begin
                        // read-word answer bit into the coder
                        bit_load = 1'b1;
                        bit_val = ANSWER_BIT;
                        nxt_busy = 1'b1;
                    end else begin
                        nxt_src = RLE_SRC_IDLE;
                    end
                end
            end
            default: begin
                nxt_src = RLE_SRC_IDLE;
            end
        endcase
    end

    // sequencer registers with synchronous reset
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            src_ff <= RLE_SRC_IDLE;
            word_ff <= 4'h0;
            shf_ff <= 32'h0000_0000;
            left_ff <= 6'h00;
            busy_ff <= 1'b0;
            wait_ff <= 1'b0;
            req_ff <= 1'b0;
        end else begin
            src_ff <= nxt_src;
            word_ff <= nxt_word;
            shf_ff <= nxt_shf;
            left_ff <= nxt_left;
            busy_ff <= nxt_busy;
            wait_ff <= nxt_wait;
            req_ff <= nxt_req;
        end
    end

    // ====================================================================
    // fetch request
    // ====================================================================
    // request and address come straight from flip-flops
    // the address stands until the next request
    assign MEM_REQ.req = req_ff;
    assign MEM_REQ.addr = word_ff;

    // ====================================================================
    // line coder
    // ====================================================================
    // one coder serves both the default frame and the answers
    rle_line_coder #(
        .RW(RW)
    ) u_coder (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .rf_tick(RF_TICK),
        .bit_load(bit_load),
        .bit_val(bit_val),
        .code(code),
        .rate(rate),
        .bit_done(bit_done),
        .mod_out(MOD_ON)
    );
endmodule : rle_return_link_encoder

// file: rle_map.svh
// constants of the return link encoder
`ifndef RLE_MAP_SVH
`define RLE_MAP_SVH
`define RLE_RATE_PIGEON 7'h40
`define RLE_RATE_FDXB 7'h20
`define RLE_PIGEON_FIRST_WORD 4'h5
`define RLE_PIGEON_LAST_WORD 4'h7
`define RLE_FDXB_FIRST_WORD 4'h5
`define RLE_FDXB_LAST_WORD 4'h8
`define RLE_FULL_WORD_BITS 6'h20
`define RLE_HALF_WORD_BITS 6'h10
`endif

// file: rle_pkg.sv
// types of the return link encoder
package rle_pkg;
    typedef enum logic {RLE_CODE_MANCHESTER, RLE_CODE_BIPHASE} rle_code_t;
    typedef enum logic [1:0] {RLE_SRC_IDLE, RLE_SRC_DEFAULT, RLE_SRC_ANSWER} rle_src_t;
    // memory fetch request and answer
    typedef struct packed {
        logic req;
        logic [3:0] addr;
    } rle_mem_req_t;
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } rle_mem_rsp_t;
endpackage : rle_pkg

// file: rle_line_coder.sv
// line coder: one nrz bit in, manchester or bi-phase level out
`timescale 1ns/100ps
`include "rle_map.svh"
module rle_line_coder
    import rle_pkg::*;
#(
    parameter int RW = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rf_tick,
    input wire logic bit_load,
    input wire logic bit_val,
    input wire rle_code_t code,
    input wire logic [RW-1:0] rate,
    output logic bit_done,
    output logic mod_out
);
    logic [RW-1:0] cnt_ff, nxt_cnt;
    logic bit_ff, nxt_bit;
    logic out_ff, nxt_out;
    logic act_ff, nxt_act;
    logic [RW-1:0] half;

    // ====================================================================
    // half-bit timing and level generation
    // ====================================================================
    // half point, rounded down for an odd rate
    assign half = rate >> 1;
    assign bit_done = act_ff && rf_tick && (cnt_ff == rate - 1'b1);

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_out = out_ff;
        nxt_act = act_ff;
        if (bit_load) begin
            nxt_bit = bit_val;
            nxt_act = 1'b1;
            nxt_cnt = '0;
            if (code == RLE_CODE_MANCHESTER) begin
                nxt_out = bit_val;
            end else begin
                // bi-phase inverts at every bit start
                nxt_out = ~out_ff;
            end
        end else if (act_ff && rf_tick) begin
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == half - 1'b1) begin
                if (code == RLE_CODE_MANCHESTER) begin
                    nxt_out = ~bit_ff; // second half is the complement
                end else if (!bit_ff) begin
                    nxt_out = ~out_ff;
                end
            end
            if (cnt_ff == rate - 1'b1) begin
                nxt_act = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            bit_ff <= 1'b0;
            out_ff <= 1'b0;
            act_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            out_ff <= nxt_out;
            act_ff <= nxt_act;
        end
    end

    // high level switches the modulator on
    assign mod_out = out_ff;
endmodule : rle_line_coder

// file: rle_mem_model.sv
// memory partner model feeding the return link encoder
`timescale 1ns/100ps
module rle_mem_model
    import rle_pkg::*;
(
    input wire logic clk,
    input wire rle_mem_req_t mem_req,
    output rle_mem_rsp_t mem_rsp
);
    logic [31:0] words [16];
    logic [3:0] addr_ff;
    int wait_ff = 0;
    logic slow_ff = 1'b0;
    initial mem_rsp = '0;
    // answer a fetch after one or three cycles, data churns when idle
    always @(posedge clk) begin
        mem_rsp.valid <= 1'b0;
        mem_rsp.data <= ~mem_rsp.data;
        if (mem_req.req) begin
            addr_ff <= mem_req.addr;
            wait_ff <= slow_ff ? 3 : 1;
            slow_ff <= ~slow_ff;
        end else if (wait_ff == 1) begin
            mem_rsp <= {1'b1, words[addr_ff]};
            wait_ff <= 0;
        end else if (wait_ff > 1) begin
            wait_ff <= wait_ff - 1;
        end
    end
endmodule : rle_mem_model

// file: rle_return_link_encoder_chk.sv
// port checker of the return link encoder
`timescale 1ns/100ps
module rle_return_link_encoder_chk
    import rle_pkg::*;
#(
    parameter int RW = 7
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic RF_TICK,
    input wire logic DEFAULT_READ_EN,
    input wire logic PIGEON_MODE_BIT,
    input wire logic ANSWER_CODE_BIPHASE,
    input wire logic [RW-1:0] ANSWER_RATE,
    input wire logic ANSWER_BIT_VALID,
    input wire logic ANSWER_BIT,
    input wire logic ANSWER_BIT_READY,
    input wire rle_mem_req_t MEM_REQ,
    input wire rle_mem_rsp_t MEM_RSP,
    input wire logic MOD_ON
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // answer bit taken
    logic take;
    assign take = ANSWER_BIT_VALID && ANSWER_BIT_READY;
    // ==========
    // properties
    property p_rst; disable iff (1'b0) !RESET_N |=> !MOD_ON && !MEM_REQ.req; endproperty
    a_rst: assert property (p_rst) else $error("active in reset");
    property p_req; MEM_REQ.req |=> !MEM_REQ.req; endproperty
    a_req: assert property (p_req) else $error("long fetch");
    property p_pig; MEM_REQ.req && PIGEON_MODE_BIT |-> MEM_REQ.addr inside {[4'h5:4'h7]}; endproperty
    a_pig: assert property (p_pig) else $error("pigeon word");
    property p_fdx; MEM_REQ.req && !PIGEON_MODE_BIT |-> MEM_REQ.addr inside {[4'h5:4'h8]}; endproperty
    a_fdx: assert property (p_fdx) else $error("frame word");
    property p_busy; take |=> !ANSWER_BIT_READY; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_man; take && !ANSWER_CODE_BIPHASE |=> MOD_ON == $past(ANSWER_BIT); endproperty
    a_man: assert property (p_man) else $error("first half");
    property p_bip; take && ANSWER_CODE_BIPHASE |=> MOD_ON != $past(MOD_ON); endproperty
    a_bip: assert property (p_bip) else $error("no start edge");
    property p_edge; $changed(MOD_ON) |-> $past(RF_TICK) || $past(take) || $past(MEM_RSP.valid, 2);
    endproperty
    a_edge: assert property (p_edge) else $error("stray edge");
    c_fdx: cover property (MEM_REQ.req && MEM_REQ.addr == 4'h8);
    c_pig: cover property (MEM_RSP.valid && PIGEON_MODE_BIT);
    c_bip: cover property (take && ANSWER_CODE_BIPHASE);
endmodule : rle_return_link_encoder_chk
bind rle_return_link_encoder rle_return_link_encoder_chk #(.RW(RW)) u_chk (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .RF_TICK(RF_TICK),
    .DEFAULT_READ_EN(DEFAULT_READ_EN), .PIGEON_MODE_BIT(PIGEON_MODE_BIT),
    .ANSWER_CODE_BIPHASE(ANSWER_CODE_BIPHASE), .ANSWER_RATE(ANSWER_RATE),
    .ANSWER_BIT_VALID(ANSWER_BIT_VALID), .ANSWER_BIT(ANSWER_BIT),
    .ANSWER_BIT_READY(ANSWER_BIT_READY), .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP), .MOD_ON(MOD_ON));

// file: rle_return_link_encoder_tb.sv
// self-checking bench of the return link encoder
`timescale 1ns/100ps
`include "rle_map.svh"
module rle_return_link_encoder_tb
    import rle_pkg::*;
;
    logic CORE_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic RF_TICK = 1'b0;
    logic DEFAULT_READ_EN = 1'b0;
    logic PIGEON_MODE_BIT = 1'b0;
    logic ANSWER_CODE_BIPHASE = 1'b0;
    logic [6:0] ANSWER_RATE = 7'h08;
    logic ANSWER_BIT_VALID = 1'b0;
    logic ANSWER_BIT = 1'b0;
    logic ANSWER_BIT_READY, MOD_ON;
    rle_mem_req_t MEM_REQ;
    rle_mem_rsp_t MEM_RSP;
    logic [1:0] exp_q[$];
    logic [1:0] tcnt = 2'h0;
    logic [63:0] code;
    logic lvl = 1'b0;
    logic arm = 1'b0;
    int seed = 32'h8A78;
    int fail_count = 0;
    int checks_done = 0;
    int rate_cur = 8;
    rle_return_link_encoder #(.RW(7)) dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
        .RF_TICK(RF_TICK), .DEFAULT_READ_EN(DEFAULT_READ_EN), .PIGEON_MODE_BIT(PIGEON_MODE_BIT),
        .ANSWER_CODE_BIPHASE(ANSWER_CODE_BIPHASE), .ANSWER_RATE(ANSWER_RATE),
        .ANSWER_BIT_VALID(ANSWER_BIT_VALID), .ANSWER_BIT(ANSWER_BIT),
        .ANSWER_BIT_READY(ANSWER_BIT_READY), .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP), .MOD_ON(MOD_ON));
    rle_mem_model mem (.clk(CORE_CLK), .mem_req(MEM_REQ), .mem_rsp(MEM_RSP));
    // clock and a field tick every fourth cycle
    initial forever #2.5 CORE_CLK = ~CORE_CLK;
    always @(negedge CORE_CLK) begin
        tcnt <= tcnt + 2'h1;
        RF_TICK <= (tcnt == 2'h3);
    end
    task automatic test_done();
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: halves %b expected %b", $time, seen, exp);
        end
    endtask : check
    task automatic reset();
        RESET_N = 1'b0;
        repeat (10) @(negedge CORE_CLK);
        RESET_N = 1'b1;
        lvl = 1'b0;
    endtask : reset
    task automatic push(input logic b, input logic bip);
        exp_q.push_back(bip ? {~lvl, b ? ~lvl : lvl} : {b, ~b});
        lvl = bip ? (b ? ~lvl : lvl) : ~b;
    endtask : push
    task automatic ticks(input int n);
        repeat (n) do @(posedge CORE_CLK); while (RF_TICK !== 1'b1);
    endtask : ticks
    // ==========
    // monitor: sample each half at its middle and compare with the oldest note
    initial begin : monitor
        logic a, b;
        forever begin
            @(posedge CORE_CLK);
            if (arm && (MEM_RSP.valid || ANSWER_BIT_VALID && ANSWER_BIT_READY)) begin
                arm = 1'b0;
                while (exp_q.size() > 0) begin
                    ticks(rate_cur / 4);
                    a = MOD_ON;
                    ticks(rate_cur / 2);
                    b = MOD_ON;
                    ticks(rate_cur - rate_cur / 4 - rate_cur / 2);
                    check({a, b}, exp_q.pop_front());
                end
            end
        end
    end
    // watchdog
    initial begin
        repeat (50000) @(posedge CORE_CLK);
        fail_count++;
        test_done();
    end
    // ==========
    // scenarios: pigeon frame, fdx-b frame, answer bits in both codings
    initial begin : main
        int i;
        reset();
        code = {$random(seed), $random(seed)};
        mem.words[5] = code[31:0];
        mem.words[6] = $random(seed);
        mem.words[7] = $random(seed);
        mem.words[6][15:0] = code[47:32];
        mem.words[7][15:0] = code[63:48];
        for (i = 0; i < 64; i++) push(code[i], 1'b0);
        rate_cur = `RLE_RATE_PIGEON;
        PIGEON_MODE_BIT = 1'b1;
        for (int k = 0; k < 4; k++) begin
            if (k == 1) begin
                for (i = 5; i < 9; i++) mem.words[i] = $random(seed);
                for (i = 0; i < 128; i++) push(mem.words[5 + i / 32][i % 32], 1'b1);
                rate_cur = `RLE_RATE_FDXB;
                PIGEON_MODE_BIT = 1'b0;
            end
            if (k > 1) begin
                ANSWER_CODE_BIPHASE = k[0];
                ANSWER_RATE = k[0] ? 7'h0C : 7'h08;
                rate_cur = ANSWER_RATE;
                code = {$random(seed), $random(seed)};
                for (i = 0; i < 16; i++) push(code[i], k[0]);
            end
            arm = 1'b1;
            DEFAULT_READ_EN = (k < 2);
            for (i = 0; i < 16 && k > 1; i++) begin
                ANSWER_BIT_VALID = 1'b1;
                ANSWER_BIT = code[i];
                // hold the bit until an edge samples ready high, then move on
                do @(posedge CORE_CLK); while (ANSWER_BIT_READY !== 1'b1);
                @(negedge CORE_CLK);
            end
            ANSWER_BIT_VALID = 1'b0;
            wait (exp_q.size() == 0);
            @(negedge CORE_CLK);
            DEFAULT_READ_EN = 1'b0;
            reset();
        end
        test_done();
    end
endmodule : rle_return_link_encoder_tb
